// >>> gpio_port.sv
// Behaviour
// - Seven pins through data register at F4h
// - Input, output, or alternate function per pin
// - High config pins 4-6, low pins 0-3
// - Reset clears both config registers to input
// - Pins 0-3 serial, timer D0, segment alternates
// - Pins 4-6 timer clocks, timer D1, segments
// - Pin 6 field: input, output, none, segment
// - Pin 5 field: input, output, PWM, segment
// - Pin 4 field: input, output, none, segment
// - Pin 1 field: input, output, none, alternate
// - Pin 0 field: input, output, serial, segment
// - Pull-up enable at F5h, bit 7 reserved
// - Pull-up off for push-pull or alternate
// - Drive select at F6h, bit 7 reserved
`timescale 1ns/1ps
`include "gpio_port_params.svh"

module gpio_port
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    // Register access
    input  wire gpio_port_pkg::reg_req_type   reg_req,
    output logic                   [7:0]      reg_rdata,
    // Pads
    input  wire logic              [6:0]      pad_in,
    output logic                   [6:0]      pad_out,
    output logic                   [6:0]      pad_oe,
    output logic                   [6:0]      pad_pullup,
    // Peripherals
    input  wire gpio_port_pkg::periph_out_type periph_out,
    output gpio_port_pkg::periph_in_type      periph_in
);

    logic [7:0] low_cfg_ff;
    logic [7:0] high_cfg_ff;
    logic [6:0] data_ff;
    logic [6:0] pullup_ff;
    logic [6:0] odrain_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_low_cfg;
    logic [7:0] nxt_high_cfg;
    logic [6:0] nxt_data;
    logic [6:0] nxt_pullup;
    logic [6:0] nxt_odrain;
    logic [7:0] nxt_rdata;
    logic [6:0] pin_level;
    logic [13:0] all_cfg;
    logic [6:0] alt_a_val;
    logic [6:0] has_alt_a;
    logic [6:0] is_input;
    logic [6:0] data_view;

    // Two-bit mode field of one pin
    function automatic logic [1:0] pin_mode(input logic [13:0] cfg,
                                            input int          pin);
        pin_mode = cfg[2*pin +: 2];
    endfunction

    // Write strobe for one register address
    function automatic logic write_hit(input gpio_port_pkg::reg_req_type req,
                                       input logic [7:0]                 addr);
        write_hit = req.write && (req.addr == addr);
    endfunction

    // Low pin configuration register
    always_comb
    begin
        nxt_low_cfg = low_cfg_ff;
        if (write_hit(reg_req, `ADDR_LOW_PIN_CONFIG))
        begin
            nxt_low_cfg = reg_req.wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            low_cfg_ff <= `CONFIG_RESET;
        end
        else
        begin
            low_cfg_ff <= nxt_low_cfg;
        end
    end

    // High pin configuration register; bits 7:6 not stored
    always_comb
    begin
        nxt_high_cfg = high_cfg_ff;
        if (write_hit(reg_req, `ADDR_HIGH_PIN_CONFIG))
        begin
            nxt_high_cfg = reg_req.wdata & `HIGH_CONFIG_MASK;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            high_cfg_ff <= `CONFIG_RESET;
        end
        else
        begin
            high_cfg_ff <= nxt_high_cfg;
        end
    end

    // Pin data latch; drives pins in output mode
    always_comb
    begin
        nxt_data = data_ff;
        if (write_hit(reg_req, `ADDR_PIN_DATA))
        begin
            nxt_data = reg_req.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            data_ff <= `DATA_RESET;
        end
        else
        begin
            data_ff <= nxt_data;
        end
    end

    // Pull-up enable; bit 7 not stored
    always_comb
    begin
        nxt_pullup = pullup_ff;
        if (write_hit(reg_req, `ADDR_PULLUP_ENABLE))
        begin
            nxt_pullup = reg_req.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pullup_ff <= `PULLUP_RESET;
        end
        else
        begin
            pullup_ff <= nxt_pullup;
        end
    end

    // Drive select; bit 7 not stored
    always_comb
    begin
        nxt_odrain = odrain_ff;
        if (write_hit(reg_req, `ADDR_OPEN_DRAIN_SEL))
        begin
            nxt_odrain = reg_req.wdata[6:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            odrain_ff <= `OPEN_DRAIN_RESET;
        end
        else
        begin
            odrain_ff <= nxt_odrain;
        end
    end

    // Read side: data reads pin level for inputs, latch for others
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_req.read)
        begin
            case (reg_req.addr)
                `ADDR_LOW_PIN_CONFIG:
                begin
                    nxt_rdata = low_cfg_ff;
                end
                `ADDR_HIGH_PIN_CONFIG:
                begin
                    nxt_rdata = high_cfg_ff;
                end
                `ADDR_PIN_DATA:
                begin
                    nxt_rdata = {1'b0, data_view};
                end
                `ADDR_PULLUP_ENABLE:
                begin
                    nxt_rdata = {1'b0, pullup_ff};
                end
                `ADDR_OPEN_DRAIN_SEL:
                begin
                    nxt_rdata = {1'b0, odrain_ff};
                end
                default:
                begin
                    nxt_rdata = 8'h00;
                end
            endcase
        end
    end

    // Read data stands one cycle, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rdata_ff <= 8'h00;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign all_cfg   = {high_cfg_ff[5:0], low_cfg_ff};

    // Software view of pin data: live level for inputs, latch otherwise
    assign data_view = (pin_level & is_input) | (data_ff & ~is_input);

    // Alternate A sources; pins 1, 4 and 6 have none
    always_comb
    begin
        alt_a_val    = 7'h00;
        alt_a_val[0] = periph_out.serial_data_out;
        alt_a_val[2] = periph_out.serial_clock_out;
        alt_a_val[3] = periph_out.timer_d0_output;
        alt_a_val[5] = periph_out.timer_d1_output;
    end

    // Pins that own a peripheral drive in mode 10
    always_comb
    begin
        has_alt_a    = 7'h00;
        has_alt_a[0] = 1'b1;
        has_alt_a[2] = 1'b1;
        has_alt_a[3] = 1'b1;
        has_alt_a[5] = 1'b1;
    end

    // Per pin drivers and input flags
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++)
        begin : pin_gen
            logic [1:0] pin_field;
            assign pin_field   = pin_mode(all_cfg, g);
            assign is_input[g] = (pin_field == `MODE_INPUT);
            gpio_pin_cell u_cell
            (
                .mode        (pin_field),
                .has_alt_a   (has_alt_a[g]),
                .open_drain  (odrain_ff[g]),
                .pullup_en   (pullup_ff[g]),
                .data_bit    (data_ff[g]),
                .alt_a_bit   (alt_a_val[g]),
                .segment_bit (periph_out.lcd_segment[g]),
                .pad_out     (pad_out[g]),
                .pad_oe      (pad_oe[g]),
                .pad_pullup  (pad_pullup[g])
            );
        end
    endgenerate

    gpio_input_sync u_sync
    (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .pad_in    (pad_in),
        .pin_level (pin_level)
    );

    // Schmitt inputs reach peripherals only in input mode
    always_comb
    begin
        periph_in.serial_data_in      = pin_level[1] & is_input[1];
        periph_in.serial_clock_in     = pin_level[2] & is_input[2];
        periph_in.timer_d0_capture_in = pin_level[3] & is_input[3];
        periph_in.timer_d0_clock_in   = pin_level[4] & is_input[4];
        periph_in.timer_d1_capture_in = pin_level[5] & is_input[5];
        periph_in.timer_d1_clock_in   = pin_level[6] & is_input[6];
    end

endmodule

// >>> gpio_port_params.svh
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define PIN_COUNT           7
`define ADDR_LOW_PIN_CONFIG 8'hef
`define ADDR_HIGH_PIN_CONFIG 8'hee
`define ADDR_PIN_DATA       8'hf4
`define ADDR_PULLUP_ENABLE  8'hf5
`define ADDR_OPEN_DRAIN_SEL 8'hf6
`define CONFIG_RESET        8'h00
`define PULLUP_RESET        7'h00
`define OPEN_DRAIN_RESET    7'h00
`define DATA_RESET          7'h00
`define HIGH_CONFIG_MASK    8'h3f
`define PIN_REG_MASK        8'h7f
`define MODE_INPUT          2'b00
`define MODE_OUTPUT         2'b01
`define MODE_ALT_A          2'b10
`define MODE_ALT_B          2'b11

`endif

// >>> gpio_port_pkg.sv
package gpio_port_pkg;

    // Register access request from the CPU register file
    typedef struct packed
    {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    // Peripheral side signals for the alternate functions
    typedef struct packed
    {
        logic serial_data_out;
        logic serial_clock_out;
        logic timer_d0_output;
        logic timer_d1_output;
        logic [6:0] lcd_segment;
    } periph_out_type;

    typedef struct packed
    {
        logic serial_data_in;
        logic serial_clock_in;
        logic timer_d0_capture_in;
        logic timer_d0_clock_in;
        logic timer_d1_capture_in;
        logic timer_d1_clock_in;
    } periph_in_type;

endpackage

// >>> gpio_pin_cell.sv
`timescale 1ns/1ps
`include "gpio_port_params.svh"

module gpio_pin_cell
(
    // Pin setup
    input  wire logic [1:0] mode,
    input  wire logic       has_alt_a,
    input  wire logic       open_drain,
    input  wire logic       pullup_en,
    // Data sources
    input  wire logic       data_bit,
    input  wire logic       alt_a_bit,
    input  wire logic       segment_bit,
    // Pad
    output logic            pad_out,
    output logic            pad_oe,
    output logic            pad_pullup
);

    logic drive_val;
    logic drive_on;

    always_comb
    begin
        drive_val = 1'b0;
        drive_on  = 1'b0;
        case (mode)
            `MODE_INPUT:
            begin
                drive_on = 1'b0;
            end
            `MODE_OUTPUT:
            begin
                drive_val = data_bit;
                drive_on  = 1'b1;
            end
            `MODE_ALT_A:
            begin
                drive_val = alt_a_bit;
                drive_on  = has_alt_a;
            end
            `MODE_ALT_B:
            begin
                drive_val = segment_bit;
                drive_on  = 1'b1;
            end
            default:
            begin
                drive_on = 1'b0;
            end
        endcase
        // Open drain only pulls low; alternates always push-pull
        pad_out = drive_val;
        pad_oe  = drive_on;
        if (mode == `MODE_OUTPUT && open_drain)
        begin
            pad_out = 1'b0;
            pad_oe  = ~data_bit;
        end
    end

    // Pull-up off for push-pull output or a real alternate only
    always_comb
    begin
        pad_pullup = pullup_en;
        if ((mode == `MODE_OUTPUT && !open_drain)
            || (mode == `MODE_ALT_A && has_alt_a)
            || mode == `MODE_ALT_B)
        begin
            pad_pullup = 1'b0;
        end
    end

endmodule

// >>> gpio_input_sync.sv
`timescale 1ns/1ps
`include "gpio_port_params.svh"

module gpio_input_sync
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    // Pad levels in and stable levels out
    input  wire logic [6:0] pad_in,
    output logic      [6:0] pin_level
);

    logic [6:0] stage_ff;
    logic [6:0] level_ff;
    logic [6:0] nxt_stage;
    logic [6:0] nxt_level;

    always_comb
    begin
        nxt_stage = pad_in;
        nxt_level = stage_ff;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            stage_ff <= `DATA_RESET;
            level_ff <= `DATA_RESET;
        end
        else
        begin
            stage_ff <= nxt_stage;
            level_ff <= nxt_level;
        end
    end

    assign pin_level = level_ff;

endmodule

// >>> gpio_port_monitor.sv
`timescale 1ns/1ps

module gpio_port_monitor
(
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         reset_n,
    // Register access
    input  wire gpio_port_pkg::reg_req_type   reg_req,
    input  wire logic [7:0]                   reg_rdata,
    // Pads and peripherals
    input  wire logic [6:0]                   pad_out,
    input  wire logic [6:0]                   pad_oe,
    input  wire logic [6:0]                   pad_pullup,
    input  wire gpio_port_pkg::periph_in_type periph_in
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_rdata_idle_zero:
        assert property (!reg_req.read |=> reg_rdata == 8'h00)
        else $error("read data not zero without read");
    a_unmapped_read_zero:
        assert property (reg_req.read && reg_req.addr == 8'h00
            |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_pullup_bit_reserved:
        assert property (reg_req.read && reg_req.addr == 8'hf5
            |=> !reg_rdata[7])
        else $error("pull-up bit 7 not zero");
    a_drive_bit_reserved:
        assert property (reg_req.read && reg_req.addr == 8'hf6
            |=> !reg_rdata[7])
        else $error("drive select bit 7 not zero");
    a_pullup_off_driving:
        assert property ((pad_pullup & pad_oe & pad_out) == 7'h00)
        else $error("pull-up on while driving high");
    a_reset_all_inputs:
        assert property ($rose(reset_n) |-> pad_oe == 7'h00
            && pad_pullup == 7'h00)
        else $error("pins not inputs after reset");
    a_low_input_undriven:
        assert property (reg_req.write && reg_req.addr == 8'hef
            && reg_req.wdata == 8'h00 |=> pad_oe[3:0] == 4'h0)
        else $error("low pins driven in input mode");
    a_pin1_serial_gated:
        assert property (pad_oe[1] |-> !periph_in.serial_data_in)
        else $error("serial input fed while pin 1 drives");
endmodule

bind gpio_port gpio_port_monitor u_mon
(
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .reg_req    (reg_req),
    .reg_rdata  (reg_rdata),
    .pad_out    (pad_out),
    .pad_oe     (pad_oe),
    .pad_pullup (pad_pullup),
    .periph_in  (periph_in)
);

// >>> gpio_pad_partner.sv
`timescale 1ns/1ps

module gpio_pad_partner
(
    // Clock
    input  wire logic                          ref_clk,
    // Pads
    input  wire logic [6:0]                    pad_out,
    input  wire logic [6:0]                    pad_oe,
    input  wire logic [6:0]                    pad_pullup,
    input  wire logic [6:0]                    ext_drive,
    input  wire logic [6:0]                    ext_level,
    output logic      [6:0]                    pad_in,
    // Peripherals
    input  wire logic                          periph_en,
    input  wire gpio_port_pkg::periph_out_type alt_val,
    output gpio_port_pkg::periph_out_type      periph_out
);
    logic [6:0] wander_ff = 7'h2a;

    // Floating pins wander so no stale level passes for a real one
    always @(posedge ref_clk)
    begin
        wander_ff <= ~wander_ff;
    end

    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
        | (~pad_oe & ~ext_drive & (pad_pullup | wander_ff));
    // Alternates act only once enabled inside the peripheral
    assign periph_out = periph_en ? alt_val : '0;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        check_count++; \
        if ((a) !== (b)) \
        begin \
            miscompares++; \
            $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end

module tb_top;
    logic                          ref_clk;
    logic                          reset_n;
    gpio_port_pkg::reg_req_type    reg_req;
    logic [7:0]                    reg_rdata;
    logic [6:0]                    pad_in;
    logic [6:0]                    pad_out;
    logic [6:0]                    pad_oe;
    logic [6:0]                    pad_pullup;
    logic [6:0]                    ext_drive;
    logic [6:0]                    ext_level;
    logic                          periph_en;
    gpio_port_pkg::periph_out_type alt_val;
    gpio_port_pkg::periph_out_type periph_out;
    gpio_port_pkg::periph_in_type  periph_in;
    int                            miscompares;
    int                            check_count;

    gpio_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .periph_out(periph_out), .periph_in(periph_in));

    gpio_pad_partner u_pads (.ref_clk(ref_clk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_drive(ext_drive),
        .ext_level(ext_level), .pad_in(pad_in), .periph_en(periph_en),
        .alt_val(alt_val), .periph_out(periph_out));

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_req <= {1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_req <= {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk);
        reg_req <= '0;
        #1;
        `CHK(reg_rdata, e)
    endtask

    task automatic t_reset;
        `CHK(pad_oe, 7'h00)
        reg_chk(8'hef, 8'h00);
        reg_chk(8'hee, 8'h00);
        reg_chk(8'hf5, 8'h00);
        reg_chk(8'hf6, 8'h00);
        reg_wr(8'h00, 8'hff);
        reg_chk(8'h00, 8'h00);
        $display("reset test done");
    endtask

    task automatic t_output;
        reg_wr(8'hf5, 8'hff);
        reg_chk(8'hf5, 8'h7f);
        reg_wr(8'hef, 8'h55);
        reg_wr(8'hee, 8'hd5);
        reg_chk(8'hee, 8'h15);
        reg_wr(8'hf4, 8'h5a);
        reg_chk(8'hf4, 8'h5a);
        `CHK(pad_oe, 7'h7f)
        `CHK(pad_out, 7'h5a)
        `CHK(pad_pullup, 7'h00)
        reg_wr(8'hf6, 8'hff);
        reg_chk(8'hf6, 8'h7f);
        `CHK(pad_oe, 7'h25)
        `CHK(pad_pullup, 7'h7f)
        $display("output test done");
    endtask

    task automatic t_input;
        reg_wr(8'hef, 8'h00);
        reg_wr(8'hee, 8'h00);
        `CHK(pad_oe, 7'h00)
        repeat (3) @(posedge ref_clk);
        reg_chk(8'hf4, 8'h7f);
        @(posedge ref_clk);
        ext_drive <= 7'h7f;
        ext_level <= 7'h2c;
        repeat (3) @(posedge ref_clk);
        reg_chk(8'hf4, 8'h2c);
        `CHK(periph_in, 6'h1a)
        @(posedge ref_clk);
        ext_drive <= 7'h00;
        $display("input test done");
    endtask

    task automatic t_alt;
        @(posedge ref_clk);
        periph_en <= 1'b1;
        alt_val <= {4'hb, 7'h55};
        reg_wr(8'hef, 8'haa);
        reg_wr(8'hee, 8'h2a);
        `CHK(pad_oe, 7'h2d)
        `CHK(pad_out & pad_oe, 7'h29)
        `CHK(pad_pullup, 7'h52)
        reg_wr(8'hef, 8'hff);
        reg_wr(8'hee, 8'h3f);
        `CHK(pad_oe, 7'h7f)
        `CHK(pad_out, 7'h55)
        `CHK(periph_in, 6'h00)
        $display("alternate test done");
    endtask

    initial
    begin
        reset_n = 1'b0;
        reg_req = '0;
        ext_drive = 7'h00;
        ext_level = 7'h00;
        periph_en = 1'b0;
        alt_val = '0;
        miscompares = 0;
        check_count = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_output();
        t_input();
        t_alt();
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        $display("[ERR] t=%0t run exceeded its cycle limit", $time);
        wrap_up();
    end
endmodule
